// ===== design/lpc_consts.svh
/*
 Offsets, field positions, reset values and cycle counts of the
 low-power mode controller. Assumes a 12-bit APB byte address.
*/
`ifndef LPC_CONSTS_SVH
`define LPC_CONSTS_SVH
`define LPC_CTRL_OFF 12'h000
`define LPC_STATUS_OFF 12'h004
`define LPC_IRQ_STAT_OFF 12'h008
`define LPC_IRQ_MASK_OFF 12'h00c
`define LPC_BKP_BASE 12'h080
`define LPC_BKP_MASK 12'hf80
`define LPC_BKP_WORDS 20
`define LPC_BKP_LAST 5'h13
`define LPC_CTRL_RESET 4'h0
`define LPC_PWR_RESET 14'h3f7c
`define LPC_MODE_SLEEP 2'h0
`define LPC_MODE_STOP 2'h1
`define LPC_MODE_STANDBY 2'h2
`define LPC_CTRL_LP_BIT 2
`define LPC_CTRL_RET_BIT 3
`define LPC_STAT_SBY_BIT 4
`define LPC_STAT_BAT_BIT 5
`define LPC_EV_SLEEP 0
`define LPC_EV_STOP 1
`define LPC_EV_STANDBY 2
`define LPC_WAKE_CYCLES 6'h20
`endif

// ===== design/lpc_pkg.sv
/*
 Types of the low-power mode controller.
 Assumes lpc_consts.svh supplies the numbers.
*/
package lpc_pkg;
    typedef enum logic [2:0] {
        ST_RUN, ST_SLEEP, ST_STOP, ST_STANDBY, ST_WAKE, ST_BATTERY
    } lpc_state_type;
    typedef struct packed {
        logic cpu_clk, core_clk, pll, rc_osc, xtal_osc;
        logic reg_on, reg_lp, core_pwr, sram_ret, bkp_sram;
        logic rtc_clk, wdg_clk, battery, core_rst;
    } lpc_pwr_type;
endpackage

// ===== design/lpc_power_ctrl.sv
/*
 Low-power mode controller: run, sleep, stop, standby and battery
 states, their clock/oscillator/regulator enables, APB registers,
 backup register bank and one level interrupt.
 Assumes all inputs synchronous to pclk; bkp_rstn is the backup domain
 power-on reset, separate from the system reset presetn.
*/
// Operation
// RQ1: sleep stops only the cpu clock, peripherals keep running.
// RQ2: in sleep any peripheral interrupt or event wakes the cpu.
// RQ3: stop gates all core-domain clocks, sram and registers retained.
// RQ4: stop disables pll, internal rc and crystal oscillators.
// RQ5: stop keeps regulator normal or low-power per software setting.
// RQ6: stop exits on any external interrupt line source.
// RQ7: standby turns regulator, core power, pll and oscillators off.
// RQ8: standby loses core state; backup regs and selected sram survive.
// RQ9: standby exits on reset pin, watchdog, wakeup pin edge, rtc event.
// RQ10: rtc, watchdog and their clocks run through stop and standby.
// RQ11: missing main supply moves the device to battery operation.
// RQ12: in battery operation rtc, backup regs and backup sram stay powered.
// RQ13: battery operation ignores external interrupts and rtc events.
// RQ14: backup registers survive system reset and standby wakeup.
// RQ15: software picks the mode; entry waits for cpu wait request.
// RQ16: standby exit runs reset sequence and flags standby wakeup.
`timescale 1ns/1ps
`include "lpc_consts.svh"
module lpc_power_ctrl (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic bkp_rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic cpu_wait_req,
    input wire logic periph_event,
    input wire logic [15:0] external_interrupt_line,
    input wire logic supply_voltage_detector_output,
    input wire logic rtc_alarm,
    input wire logic rtc_wakeup,
    input wire logic rtc_tamper,
    input wire logic rtc_timestamp,
    input wire logic usb_wakeup,
    input wire logic eth_wakeup,
    input wire logic external_reset_pin_n,
    input wire logic independent_watchdog_reset,
    input wire logic wakeup_pin,
    input wire logic main_supply_ok,
    output logic cpu_clk_en,
    output logic core_clk_en,
    output logic pll_en,
    output logic internal_rc_oscillator_en,
    output logic external_crystal_oscillator_en,
    output logic regulator_on,
    output logic regulator_lp,
    output logic core_power_on,
    output logic sram_retain,
    output logic bkp_sram_power,
    output logic rtc_clk_en,
    output logic watchdog_clk_en,
    output logic battery_mode,
    output logic core_reset,
    output logic irq
);
    lpc_pkg::lpc_state_type st, next_st;
    lpc_pkg::lpc_pwr_type pwr, next_pwr;
    logic [3:0] ctrl, next_ctrl;
    logic sby_flag, next_sby_flag;
    logic [2:0] irq_stat, next_irq_stat;
    logic [2:0] irq_mask, next_irq_mask;
    logic [5:0] wake_cnt, next_wake_cnt;
    logic wakeup_pin_prev;
    logic [31:0] next_prdata;
    logic next_pready, next_pslverr, next_irq;
    logic [31:0] bkp [`LPC_BKP_WORDS];
    logic [31:0] next_bkp [`LPC_BKP_WORDS];
    logic setup, acc, wr, is_bkp, bkp_we;
    logic [4:0] bkp_idx;
    logic stop_src, stby_src;
    logic [2:0] ev;

    // any external interrupt line source
    assign stop_src = (|external_interrupt_line)
        | supply_voltage_detector_output | rtc_alarm | rtc_wakeup
        | rtc_tamper | rtc_timestamp | usb_wakeup | eth_wakeup; // RQ6
    assign stby_src = !external_reset_pin_n | independent_watchdog_reset
        | (wakeup_pin & !wakeup_pin_prev) | rtc_alarm | rtc_wakeup
        | rtc_tamper | rtc_timestamp; // RQ9

    assign setup = psel && !penable;
    assign acc = psel && penable && pready;
    assign wr = acc && pwrite && !pslverr;
    assign is_bkp = (paddr & `LPC_BKP_MASK) == `LPC_BKP_BASE
        && paddr[6:2] <= `LPC_BKP_LAST;
    assign bkp_idx = paddr[6:2];
    assign bkp_we = wr && is_bkp;

    always_comb
    begin
        next_st = st;
        next_wake_cnt = wake_cnt;
        next_sby_flag = sby_flag;
        ev = 3'h0;
        if (wr && paddr == `LPC_STATUS_OFF && pwdata[`LPC_STAT_SBY_BIT])
        begin
            next_sby_flag = 1'b0;
        end
        case (st)
            lpc_pkg::ST_RUN:
            begin
                if (cpu_wait_req) // RQ15
                begin
                    case (ctrl[1:0])
                        `LPC_MODE_STOP: next_st = lpc_pkg::ST_STOP;
                        `LPC_MODE_STANDBY: next_st = lpc_pkg::ST_STANDBY;
                        default: next_st = lpc_pkg::ST_SLEEP;
                    endcase
                end
            end
            lpc_pkg::ST_SLEEP:
            begin
                if (periph_event || stop_src) // RQ2
                begin
                    next_st = lpc_pkg::ST_RUN;
                    ev[`LPC_EV_SLEEP] = 1'b1;
                end
            end
            lpc_pkg::ST_STOP:
            begin
                if (stop_src) // RQ6
                begin
                    next_st = lpc_pkg::ST_RUN;
                    ev[`LPC_EV_STOP] = 1'b1;
                end
            end
            lpc_pkg::ST_STANDBY:
            begin
                if (stby_src) // RQ9
                begin
                    next_st = lpc_pkg::ST_WAKE;
                    next_wake_cnt = `LPC_WAKE_CYCLES;
                    next_sby_flag = 1'b1; // RQ16
                end
            end
            lpc_pkg::ST_WAKE:
            begin
                next_wake_cnt = wake_cnt - 6'h01;
                if (wake_cnt == 6'h01)
                begin
                    next_st = lpc_pkg::ST_RUN;
                    ev[`LPC_EV_STANDBY] = sby_flag;
                end
            end
            default:
            begin
                // events are ignored; only supply return leaves battery
                if (main_supply_ok) // RQ13
                begin
                    next_st = lpc_pkg::ST_WAKE;
                    next_wake_cnt = `LPC_WAKE_CYCLES;
                end
            end
        endcase
        if (!main_supply_ok) // RQ11
        begin
            next_st = lpc_pkg::ST_BATTERY;
        end
    end

    always_comb
    begin
        next_ctrl = ctrl;
        next_irq_mask = irq_mask;
        if (wr && paddr == `LPC_CTRL_OFF)
        begin
            next_ctrl = pwdata[3:0];
        end
        if (wr && paddr == `LPC_IRQ_MASK_OFF)
        begin
            next_irq_mask = pwdata[2:0];
        end
        // core-domain settings are lost in standby; retention is kept
        if (next_st == lpc_pkg::ST_WAKE && st != lpc_pkg::ST_WAKE)
        begin
            next_ctrl = {ctrl[`LPC_CTRL_RET_BIT], 3'h0}; // RQ8
            next_irq_mask = 3'h0;
        end
        // only bits the read actually returned are cleared; set wins
        next_irq_stat = irq_stat;
        if (acc && !pwrite && paddr == `LPC_IRQ_STAT_OFF)
        begin
            next_irq_stat = irq_stat & ~prdata[2:0];
        end
        next_irq_stat = next_irq_stat | ev;
        next_irq = |(next_irq_stat & next_irq_mask);
    end

    always_comb
    begin
        next_pwr = '0;
        next_pwr.rtc_clk = 1'b1; // RQ10
        next_pwr.wdg_clk = 1'b1; // RQ10
        next_pwr.bkp_sram = 1'b1;
        next_pwr.reg_on = 1'b1;
        next_pwr.core_pwr = 1'b1;
        next_pwr.sram_ret = 1'b1;
        case (next_st)
            lpc_pkg::ST_RUN, lpc_pkg::ST_SLEEP, lpc_pkg::ST_WAKE:
            begin
                next_pwr.cpu_clk = next_st == lpc_pkg::ST_RUN; // RQ1
                next_pwr.core_clk = 1'b1;
                next_pwr.pll = 1'b1;
                next_pwr.rc_osc = 1'b1;
                next_pwr.xtal_osc = 1'b1;
                next_pwr.core_rst = next_st == lpc_pkg::ST_WAKE; // RQ16
            end
            lpc_pkg::ST_STOP:
            begin
                next_pwr.core_clk = 1'b0; // RQ3
                next_pwr.pll = 1'b0; // RQ4
                next_pwr.reg_lp = next_ctrl[`LPC_CTRL_LP_BIT]; // RQ5
            end
            lpc_pkg::ST_STANDBY:
            begin
                next_pwr.reg_on = 1'b0; // RQ7
                next_pwr.core_pwr = 1'b0;
                next_pwr.sram_ret = 1'b0; // RQ8
                next_pwr.bkp_sram = next_ctrl[`LPC_CTRL_RET_BIT];
            end
            default:
            begin
                next_pwr.reg_on = 1'b0;
                next_pwr.core_pwr = 1'b0;
                next_pwr.sram_ret = 1'b0;
                next_pwr.battery = 1'b1; // RQ12
            end
        endcase
    end

    always_comb
    begin
        next_pready = setup;
        next_pslverr = 1'b0;
        next_prdata = 32'h0;
        if (setup)
        begin
            if (paddr == `LPC_CTRL_OFF)
            begin
                next_prdata = {28'h0, ctrl};
            end
            else if (paddr == `LPC_STATUS_OFF)
            begin
                next_prdata = {26'h0, pwr.battery, sby_flag, 1'b0, st};
            end
            else if (paddr == `LPC_IRQ_STAT_OFF)
            begin
                next_prdata = {29'h0, irq_stat};
            end
            else if (paddr == `LPC_IRQ_MASK_OFF)
            begin
                next_prdata = {29'h0, irq_mask};
            end
            else if (is_bkp)
            begin
                next_prdata = bkp[bkp_idx];
            end
            else
            begin
                next_pslverr = 1'b1;
            end
        end
    end

    // backup bank sits on the backup reset only
    for (genvar i = 0; i < `LPC_BKP_WORDS; i++)
    begin : g_bkp
        always_comb
        begin
            next_bkp[i] = bkp[i];
            if (bkp_we && bkp_idx == 5'(i))
            begin
                next_bkp[i] = pwdata;
            end
        end
        always_ff @(posedge pclk or negedge bkp_rstn)
        begin
            if (!bkp_rstn)
            begin
                bkp[i] <= 32'h0;
            end
            else
            begin
                bkp[i] <= next_bkp[i]; // RQ14
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st <= lpc_pkg::ST_RUN;
            pwr <= `LPC_PWR_RESET;
            ctrl <= `LPC_CTRL_RESET;
            sby_flag <= 1'b0;
            irq_stat <= 3'h0;
            irq_mask <= 3'h0;
            wake_cnt <= 6'h0;
            wakeup_pin_prev <= 1'b0;
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
            irq <= 1'b0;
        end
        else
        begin
            st <= next_st;
            pwr <= next_pwr;
            ctrl <= next_ctrl;
            sby_flag <= next_sby_flag;
            irq_stat <= next_irq_stat;
            irq_mask <= next_irq_mask;
            wake_cnt <= next_wake_cnt;
            wakeup_pin_prev <= wakeup_pin;
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
            irq <= next_irq;
        end
    end

    assign cpu_clk_en = pwr.cpu_clk;
    assign core_clk_en = pwr.core_clk;
    assign pll_en = pwr.pll;
    assign internal_rc_oscillator_en = pwr.rc_osc;
    assign external_crystal_oscillator_en = pwr.xtal_osc;
    assign regulator_on = pwr.reg_on;
    assign regulator_lp = pwr.reg_lp;
    assign core_power_on = pwr.core_pwr;
    assign sram_retain = pwr.sram_ret;
    assign bkp_sram_power = pwr.bkp_sram;
    assign rtc_clk_en = pwr.rtc_clk;
    assign watchdog_clk_en = pwr.wdg_clk;
    assign battery_mode = pwr.battery;
    assign core_reset = pwr.core_rst;

    a_sleep_cpu_only: assert property (@(posedge pclk) disable iff (!presetn) // RQ1
        st == lpc_pkg::ST_SLEEP |-> !cpu_clk_en && core_clk_en && pll_en)
        else $error("sleep did not stop only the cpu clock");
    a_sleep_wake: assert property (@(posedge pclk) disable iff (!presetn) // RQ2
        st == lpc_pkg::ST_SLEEP && periph_event && main_supply_ok
        |=> st == lpc_pkg::ST_RUN && cpu_clk_en && irq_stat[0])
        else $error("sleep wake missed");
    a_stop_gated: assert property (@(posedge pclk) disable iff (!presetn) // RQ3
        st == lpc_pkg::ST_STOP |-> !core_clk_en && !pll_en
        && !internal_rc_oscillator_en && !external_crystal_oscillator_en
        && sram_retain && core_power_on)
        else $error("stop left a clock or lost retention");
    a_stop_reg_mode: assert property (@(posedge pclk) disable iff (!presetn) // RQ5
        st == lpc_pkg::ST_STOP |-> regulator_on
        && regulator_lp == ctrl[`LPC_CTRL_LP_BIT])
        else $error("stop regulator mode wrong");
    a_stop_wake: assert property (@(posedge pclk) disable iff (!presetn) // RQ6
        st == lpc_pkg::ST_STOP && stop_src && main_supply_ok
        |=> st == lpc_pkg::ST_RUN)
        else $error("stop wake missed");
    a_standby_off: assert property (@(posedge pclk) disable iff (!presetn) // RQ7
        st == lpc_pkg::ST_STANDBY |-> !regulator_on && !core_power_on
        && !pll_en && !sram_retain && rtc_clk_en && watchdog_clk_en)
        else $error("standby power state wrong");
    a_standby_exit: assert property (@(posedge pclk) disable iff (!presetn) // RQ9
        st == lpc_pkg::ST_STANDBY && stby_src && main_supply_ok
        |=> st == lpc_pkg::ST_WAKE && core_reset && sby_flag && ctrl[1:0] == 2'h0)
        else $error("standby exit wrong");
    a_battery_enter: assert property (@(posedge pclk) disable iff (!presetn) // RQ11
        !main_supply_ok |=> battery_mode && bkp_sram_power && rtc_clk_en)
        else $error("battery operation not entered");
    a_battery_hold: assert property (@(posedge pclk) disable iff (!presetn) // RQ13
        st == lpc_pkg::ST_BATTERY && !main_supply_ok && $past(st) == st
        |=> $stable(irq_stat) && st == lpc_pkg::ST_BATTERY)
        else $error("battery operation left by an event");
    a_entry_waits: assert property (@(posedge pclk) disable iff (!presetn) // RQ15
        st == lpc_pkg::ST_RUN && !cpu_wait_req && main_supply_ok
        |=> st == lpc_pkg::ST_RUN)
        else $error("low-power entry without cpu wait");
endmodule // lpc_power_ctrl

// ===== tb/lpc_wake_model.sv
/*
 Far-side model: cpu wait request, peripheral event and every wakeup
 source of the low-power controller.
 Assumes the bench raises fire with a source index; that source is
 active in the cycle after each cycle that fire is high, idle otherwise.
*/
`timescale 1ns/1ps
module lpc_wake_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic fire,
    input wire logic [4:0] src_sel,
    output logic cpu_wait_req,
    output logic periph_event,
    output logic [15:0] external_interrupt_line,
    output logic supply_voltage_detector_output,
    output logic rtc_alarm,
    output logic rtc_wakeup,
    output logic rtc_tamper,
    output logic rtc_timestamp,
    output logic usb_wakeup,
    output logic eth_wakeup,
    output logic external_reset_pin_n,
    output logic independent_watchdog_reset,
    output logic wakeup_pin
);
    // index map: 0-15 lines, 16-22 other stop sources, 23 peripheral,
    // 24 reset pin, 25 watchdog, 26 wakeup pin, 27 cpu wait
    logic [27:0] act;
    logic [27:0] next_act;
    always_comb
    begin
        next_act = 28'h0000000;
        if (fire)
        begin
            next_act[src_sel] = 1'b1;
        end
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            act <= 28'h0000000;
        end
        else
        begin
            act <= next_act;
        end
    end
    assign external_interrupt_line = act[15:0];
    assign supply_voltage_detector_output = act[16];
    assign rtc_alarm = act[17];
    assign rtc_wakeup = act[18];
    assign rtc_tamper = act[19];
    assign rtc_timestamp = act[20];
    assign usb_wakeup = act[21];
    assign eth_wakeup = act[22];
    assign periph_event = act[23];
    // the reset pin idles high, the wakeup pin idles low
    assign external_reset_pin_n = ~act[24];
    assign independent_watchdog_reset = act[25];
    assign wakeup_pin = act[26];
    assign cpu_wait_req = act[27];
endmodule // lpc_wake_model

// ===== tb/test_lpc_power_ctrl.sv
/*
 Self-checking bench of the low-power mode controller: APB tasks, the
 wake-source model and mode walks with expected enables.
 Assumes lpc_consts.svh on the include path and a 100 MHz pclk.
*/
`timescale 1ns/1ps
`include "lpc_consts.svh"
module test_lpc_power_ctrl;
    localparam logic [13:0] P_RUN = 14'h3f7c;
    localparam logic [13:0] P_ALL = 14'h3fff;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic bkp_rstn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic fire = 1'b0;
    logic [4:0] src_sel = 5'h00;
    logic main_supply_ok = 1'b1;
    logic [31:0] prdata;
    logic pready, pslverr, cpu_wait_req, periph_event, irq;
    logic [15:0] external_interrupt_line;
    logic supply_voltage_detector_output, rtc_alarm, rtc_wakeup;
    logic rtc_tamper, rtc_timestamp, usb_wakeup, eth_wakeup;
    logic external_reset_pin_n, independent_watchdog_reset, wakeup_pin;
    logic cpu_clk_en, core_clk_en, pll_en, internal_rc_oscillator_en;
    logic external_crystal_oscillator_en, regulator_on, regulator_lp;
    logic core_power_on, sram_retain, bkp_sram_power, rtc_clk_en;
    logic watchdog_clk_en, battery_mode, core_reset;
    logic [13:0] pwr;
    logic [31:0] rdat;
    logic rerr;
    logic [4:0] sby_src [7] = '{5'h18, 5'h19, 5'h1a, 5'h11, 5'h12,
        5'h13, 5'h14};
    int mismatches = 0;
    int comparisons = 0;
    int k;
    always #5 pclk = ~pclk;
    assign pwr = {cpu_clk_en, core_clk_en, pll_en,
        internal_rc_oscillator_en, external_crystal_oscillator_en,
        regulator_on, regulator_lp, core_power_on, sram_retain,
        bkp_sram_power, rtc_clk_en, watchdog_clk_en, battery_mode,
        core_reset};
    lpc_power_ctrl dut_u (.pclk, .presetn, .bkp_rstn, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .cpu_wait_req, .periph_event, .external_interrupt_line,
        .supply_voltage_detector_output, .rtc_alarm, .rtc_wakeup,
        .rtc_tamper, .rtc_timestamp, .usb_wakeup, .eth_wakeup,
        .external_reset_pin_n, .independent_watchdog_reset, .wakeup_pin,
        .main_supply_ok, .cpu_clk_en, .core_clk_en, .pll_en,
        .internal_rc_oscillator_en, .external_crystal_oscillator_en,
        .regulator_on, .regulator_lp, .core_power_on, .sram_retain,
        .bkp_sram_power, .rtc_clk_en, .watchdog_clk_en, .battery_mode,
        .core_reset, .irq);
    lpc_wake_model wake_u (.pclk, .presetn, .fire, .src_sel,
        .cpu_wait_req, .periph_event, .external_interrupt_line,
        .supply_voltage_detector_output, .rtc_alarm, .rtc_wakeup,
        .rtc_tamper, .rtc_timestamp, .usb_wakeup, .eth_wakeup,
        .external_reset_pin_n, .independent_watchdog_reset, .wakeup_pin);
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
        begin
            $display("Simulation passed");
        end
        else
        begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            mismatches++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        chk_word({31'h0, got}, {31'h0, exp});
    endtask
    // masked-out enables are ones that the mode leaves open
    task automatic chk_pwr(input logic [13:0] exp, input logic [13:0] m);
        chk_word({18'h0, pwr & m}, {18'h0, exp & m});
    endtask
    task automatic settle(input int w);
        repeat (w) @(posedge pclk);
        #1;
    endtask
    task automatic apb(input logic wr, input logic [11:0] a,
        input logic [31:0] wd);
        int t = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && t < 20)
        begin
            t++;
            @(posedge pclk);
        end
        if (t >= 20)
        begin
            mismatches++;
            close_out();
        end
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h00000000);
        chk_word(rdat, exp);
    endtask
    task automatic kick(input logic [4:0] s, input int w);
        @(posedge pclk);
        src_sel <= s;
        fire <= 1'b1;
        @(posedge pclk);
        fire <= 1'b0;
        settle(w);
    endtask
    // counts the cycles of the wake reset sequence, bounded at 100
    task automatic wake_count;
        int cnt = 0;
        for (int n = 0; n < 100; n++)
        begin
            settle(1);
            if (core_reset === 1'b1)
            begin
                cnt++;
            end
            else if (cnt > 0)
            begin
                break;
            end
            if (cnt == 1)
            begin
                chk_pwr(14'h094d, 14'h094f);
            end
        end
        chk_word(cnt, {26'h0, `LPC_WAKE_CYCLES});
        chk_pwr(P_RUN, P_ALL);
    endtask
    initial
    begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        bkp_rstn <= 1'b1;
        settle(0);
        chk_pwr(P_RUN, P_ALL);
        chk_bit(irq, 1'b0);
        apb(1'b1, `LPC_BKP_BASE, 32'h5a5a0001);
        apb(1'b1, 12'h0cc, 32'hc3c30013);
        apb(1'b1, 12'h010, 32'hffffffff);
        chk_bit(rerr, 1'b1);
        apb(1'b0, 12'h010, 32'h00000000);
        chk_bit(rerr, 1'b1);
        chk_word(rdat, 32'h00000000);
        rd_chk(`LPC_STATUS_OFF, 32'h00000000);
        apb(1'b1, `LPC_IRQ_MASK_OFF, 32'h00000001);
        apb(1'b1, `LPC_CTRL_OFF, {30'h0, `LPC_MODE_SLEEP});
        settle(3);
        chk_pwr(P_RUN, P_ALL);
        kick(5'h1b, 3);
        chk_pwr(14'h1f7c, P_ALL);
        rd_chk(`LPC_STATUS_OFF, 32'h00000001);
        kick(5'h17, 3);
        chk_pwr(P_RUN, P_ALL);
        chk_bit(irq, 1'b1);
        rd_chk(`LPC_IRQ_STAT_OFF, 32'h00000001);
        settle(2);
        chk_bit(irq, 1'b0);
        apb(1'b1, `LPC_CTRL_OFF, 32'h00000003);
        kick(5'h1b, 3);
        chk_pwr(14'h1f7c, P_ALL);
        kick(5'h10, 3);
        chk_pwr(P_RUN, P_ALL);
        rd_chk(`LPC_IRQ_STAT_OFF, 32'h00000001);
        for (k = 0; k < 23; k++)
        begin
            apb(1'b1, `LPC_CTRL_OFF, {29'h0, k[0], `LPC_MODE_STOP});
            kick(5'h1b, 3);
            chk_pwr({6'h01, k[0], 7'h6c}, 14'h3fef);
            kick(5'h17, 3);
            chk_pwr({6'h01, k[0], 7'h6c}, 14'h3fef);
            kick(k[4:0], 3);
            chk_pwr(P_RUN, P_ALL);
        end
        chk_bit(irq, 1'b0);
        apb(1'b1, `LPC_IRQ_MASK_OFF, 32'h00000002);
        settle(2);
        chk_bit(irq, 1'b1);
        rd_chk(`LPC_IRQ_STAT_OFF, 32'h00000002);
        for (k = 0; k < 7; k++)
        begin
            apb(1'b1, `LPC_CTRL_OFF, {28'h0, k[0], 1'b0, `LPC_MODE_STANDBY});
            kick(5'h1b, 3);
            chk_pwr({9'h000, k[0], 4'hc}, 14'h3f7f);
            kick(5'h00, 3);
            chk_pwr({9'h000, k[0], 4'hc}, 14'h3f7f);
            kick(sby_src[k], 0);
            wake_count();
            rd_chk(`LPC_STATUS_OFF, 32'h00000010);
            apb(1'b1, `LPC_STATUS_OFF, 32'h00000010);
            rd_chk(`LPC_STATUS_OFF, 32'h00000000);
            rd_chk(`LPC_CTRL_OFF, {28'h0, k[0], 3'h0});
            rd_chk(`LPC_BKP_BASE, 32'h5a5a0001);
            rd_chk(`LPC_IRQ_STAT_OFF, 32'h00000004);
        end
        @(posedge pclk);
        main_supply_ok <= 1'b0;
        settle(3);
        chk_pwr(14'h001a, 14'h001a);
        rd_chk(`LPC_STATUS_OFF, 32'h00000025);
        kick(5'h03, 3);
        kick(5'h11, 3);
        chk_pwr(14'h001a, 14'h001a);
        @(posedge pclk);
        main_supply_ok <= 1'b1;
        wake_count();
        rd_chk(`LPC_BKP_BASE, 32'h5a5a0001);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        settle(1);
        chk_pwr(P_RUN, P_ALL);
        rd_chk(12'h0cc, 32'hc3c30013);
        @(posedge pclk);
        bkp_rstn <= 1'b0;
        repeat (2) @(posedge pclk);
        bkp_rstn <= 1'b1;
        rd_chk(`LPC_BKP_BASE, 32'h00000000);
        close_out();
    end
endmodule // test_lpc_power_ctrl
